// ===== bacs_alu_top.sv
/*
 * Execution unit for the decimal adjust and compare-skip-less
 * instructions, with working register, carry flags and data memory,
 * all reached as an AHB-Lite slave.
 * Assumes single word transfers from one master; hready is the bus
 * ready that this slave's hreadyout feeds.
 */
`timescale 1ns/10ps

// Operation
// - Low nibble over nine or digit carry: add six
// - High nibble over nine or carry: add six
// - Adjust raw BCD sum into valid BCD
// - Select clear: write memory and working register
// - Select set: write memory only
module bacs_alu_top
	import bacs_pkg::*;
#(
	parameter int MEM_DEPTH = 256
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	output logic             flush_pulse,
	output logic             done_pulse
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DECODE,
		ST_READ,
		ST_EXEC,
		ST_WRITE,
		ST_FNOP
	} bacs_state_t;

	////////////////////////////////////////////////////////////////////////
	// Registers
	bacs_state_t state_q, state_d;
	bacs_ctrl_t  ctrl_q;
	bacs_flags_t flags_q;
	logic [7:0]  working_register_q;
	logic [7:0]  maddr_q;
	logic [7:0]  res_q;
	logic        res_carry_q;
	logic        skip_q;
	logic [1:0]  phase_q;
	logic [1:0]  cycles_q;
	logic        dp_act_q;
	logic        ap_write_q;
	logic [7:0]  ap_addr_q;
	logic [1:0]  wcnt_q;
	logic        hreadyout_q, hreadyout_d;
	logic [31:0] hrdata_q;
	logic        hresp_q;
	logic        flush_q;
	logic        done_q;

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	logic        accept;
	logic        stalled;
	logic        xfer_done;
	logic        wr_done;
	logic        rd_go;
	logic        busy_q;
	logic        busy_d;
	logic        sel_ctrl;
	logic        sel_work;
	logic        sel_flags;
	logic        sel_status;
	logic        sel_maddr;
	logic        sel_mdata;
	logic        launch;
	logic [1:0]  wr_op;
	logic [31:0] rd_word;
	logic [31:0] status_word;
	logic [7:0]  mem_rd_data;

	assign accept     = hsel & htrans[1] & hready;
	assign stalled    = dp_act_q & ~hreadyout_q;
	assign xfer_done  = dp_act_q & hreadyout_q;
	assign wr_done    = xfer_done & ap_write_q;
	assign busy_q     = (state_q != ST_IDLE);
	assign busy_d     = (state_d != ST_IDLE);
	assign rd_go      = stalled & ~ap_write_q & ~busy_q & (wcnt_q == RD_WAIT);

	assign sel_ctrl   = (ap_addr_q == OFS_CTRL);
	assign sel_work   = (ap_addr_q == OFS_WORK);
	assign sel_flags  = (ap_addr_q == OFS_FLAGS);
	assign sel_status = (ap_addr_q == OFS_STATUS);
	assign sel_maddr  = (ap_addr_q == OFS_MADDR);
	assign sel_mdata  = (ap_addr_q == OFS_MDATA);

	assign wr_op      = hwdata[CTRL_OP_LSB +: 2];
	assign launch     = wr_done & sel_ctrl & ((wr_op == OP_ADJ) | (wr_op == OP_CSLT));

	assign status_word = {24'h00_0000, 2'h0, cycles_q, 2'h0, skip_q, busy_q};

	assign rd_word = sel_ctrl   ? {16'h0000, ctrl_q.f_addr, 3'h0, ctrl_q.dest_mem_only, 2'h0, ctrl_q.op} :
	                 sel_work   ? {24'h00_0000, working_register_q} :
	                 sel_flags  ? {30'h0000_0000, flags_q.digit_carry_flag, flags_q.carry} :
	                 sel_status ? status_word :
	                 sel_maddr  ? {24'h00_0000, maddr_q} :
	                 sel_mdata  ? {24'h00_0000, mem_rd_data} :
	                 WORD_ZERO;

	////////////////////////////////////////////////////////////////////////
	// Data memory
	logic       mem_we;
	logic [7:0] mem_wr_addr;
	logic [7:0] mem_wr_data;
	logic [7:0] mem_rd_addr;
	logic       eng_mem_we;

	// Adjusted result always lands in the addressed location
	assign eng_mem_we  = (state_q == ST_WRITE) & (ctrl_q.op == OP_ADJ);
	assign mem_we      = eng_mem_we | (wr_done & sel_mdata);
	assign mem_wr_addr = eng_mem_we ? ctrl_q.f_addr : maddr_q;
	assign mem_wr_data = eng_mem_we ? res_q : hwdata[7:0];
	assign mem_rd_addr = busy_q ? ctrl_q.f_addr : maddr_q;

	bacs_data_mem #(
		.WIDTH (8),
		.DEPTH (MEM_DEPTH),
		.AW    (8)
	) u_mem (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.wr_en     (mem_we),
		.wr_addr   (mem_wr_addr),
		.wr_data   (mem_wr_data),
		.rd_addr   (mem_rd_addr),
		.rd_data_q (mem_rd_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Decimal adjust datapath
	logic [3:0] adj_lo;
	logic [3:0] adj_hi;
	logic       hi_carry;
	logic [7:0] adj_result;
	logic       cslt_less;

	bacs_nibble_adj u_adj_lo (
		.digit     (working_register_q[3:0]),
		.force_adj (flags_q.digit_carry_flag),
		.carry_in  (1'b0),
		.result    (adj_lo),
		.carry_out ()
	);

	// Digits correct independently; no carry passes from low to high
	bacs_nibble_adj u_adj_hi (
		.digit     (working_register_q[7:4]),
		.force_adj (flags_q.carry),
		.carry_in  (1'b0),
		.result    (adj_hi),
		.carry_out (hi_carry)
	);

	assign adj_result = {adj_hi, adj_lo};
	assign cslt_less  = (mem_rd_data < working_register_q);

	////////////////////////////////////////////////////////////////////////
	// Instruction sequencer: decode, read, execute, write, optional no-op
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (launch) begin
					state_d = ST_DECODE;
				end
			end
			ST_DECODE: begin
				state_d = ST_READ;
			end
			ST_READ: begin
				state_d = ST_EXEC;
			end
			ST_EXEC: begin
				state_d = ST_WRITE;
			end
			ST_WRITE: begin
				state_d = skip_q ? ST_FNOP : ST_IDLE;
			end
			ST_FNOP: begin
				if (phase_q == NOP_LAST_PH) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_IDLE;
			phase_q <= 2'h0;
		end else begin
			state_q <= state_d;
			phase_q <= (state_q == ST_FNOP) ? phase_q + 2'h1 : 2'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= CTRL_RST;
		end else if (launch) begin
			ctrl_q.op            <= wr_op;
			ctrl_q.dest_mem_only <= hwdata[CTRL_DEST_BIT];
			ctrl_q.f_addr        <= hwdata[CTRL_F_LSB +: 8];
		end
	end

	// Execute phase captures the result, carry and skip decision
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_q       <= WORK_RST;
			res_carry_q <= 1'b0;
			skip_q      <= 1'b0;
		end else if (state_q == ST_EXEC) begin
			res_q       <= adj_result;
			res_carry_q <= hi_carry;
			skip_q      <= (ctrl_q.op == OP_CSLT) & cslt_less;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			working_register_q <= WORK_RST;
		end else if (eng_mem_we & ~ctrl_q.dest_mem_only) begin
			working_register_q <= res_q;
		end else if (wr_done & sel_work) begin
			working_register_q <= hwdata[7:0];
		end
	end

	// Compare leaves flags alone; adjust updates carry only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q <= FLAGS_RST;
		end else if (eng_mem_we) begin
			flags_q.carry <= res_carry_q;
		end else if (wr_done & sel_flags) begin
			flags_q.carry            <= hwdata[FLG_C_BIT];
			flags_q.digit_carry_flag <= hwdata[FLG_DIG_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			maddr_q <= MADDR_RST;
		end else if (wr_done & sel_maddr) begin
			maddr_q <= hwdata[7:0];
		end
	end

	// Pulses: prefetch discard at end of the skipping cycle, then done
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flush_q  <= 1'b0;
			done_q   <= 1'b0;
			cycles_q <= 2'h0;
		end else begin
			flush_q <= (state_q == ST_WRITE) & skip_q;
			done_q  <= busy_q & ~busy_d;
			if (busy_q & ~busy_d) begin
				cycles_q <= (state_q == ST_FNOP) ? CYC_DOUBLE : CYC_SINGLE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: writes wait only while busy, reads add two waits
	always_comb begin
		if (accept) begin
			hreadyout_d = hwrite & ~busy_d;
		end else if (stalled) begin
			hreadyout_d = ap_write_q ? ~busy_d : rd_go;
		end else begin
			hreadyout_d = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_act_q   <= 1'b0;
			ap_write_q <= 1'b0;
			ap_addr_q  <= 8'h00;
		end else if (accept) begin
			dp_act_q   <= 1'b1;
			ap_write_q <= hwrite;
			ap_addr_q  <= {haddr[7:2], 2'h0};
		end else if (xfer_done) begin
			dp_act_q   <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wcnt_q <= 2'h0;
		end else if (accept | busy_q) begin
			wcnt_q <= 2'h0;
		end else if (stalled & (wcnt_q != RD_WAIT)) begin
			wcnt_q <= wcnt_q + 2'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
			hrdata_q    <= WORD_ZERO;
			hresp_q     <= 1'b0;
		end else begin
			hreadyout_q <= hreadyout_d;
			hresp_q     <= 1'b0;
			if (rd_go) begin
				hrdata_q <= rd_word;
			end
		end
	end

	assign hreadyout   = hreadyout_q;
	assign hrdata      = hrdata_q;
	assign hresp       = hresp_q;
	assign flush_pulse = flush_q;
	assign done_pulse  = done_q;

endmodule : bacs_alu_top

// ===== bacs_alu_top_props.sv
/*
 * Port checker for the decimal adjust / compare-skip-less block.
 * Assumes one hclk domain and the bench's AHB-Lite single transfers.
 */
`timescale 1ns/10ps
module bacs_props_chk #(
	parameter int MEM_DEPTH = 256
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	input wire logic        flush_pulse,
	input wire logic        done_pulse
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic rd_take = hsel && htrans[1] && !hwrite && hready;
	sequence s_wait2; !hreadyout [*2]; endsequence
	sequence s_nop_tail; !done_pulse [*3] ##1 done_pulse; endsequence
	property p_okay; hresp == 1'b0; endproperty
	property p_flush_one; flush_pulse |=> !flush_pulse; endproperty
	property p_done_one; done_pulse |=> !done_pulse; endproperty
	property p_skip_done; flush_pulse |=> s_nop_tail; endproperty
	property p_excl; flush_pulse |-> !done_pulse; endproperty
	property p_rd_wait; rd_take |=> s_wait2; endproperty
	property p_rd_bound; rd_take |-> ##[3:16] hreadyout; endproperty
	property p_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
	a_okay: assert property (p_okay) else $error("response not OKAY");
	a_flush_one: assert property (p_flush_one) else $error("flush longer than a cycle");
	a_done_one: assert property (p_done_one) else $error("done longer than a cycle");
	a_skip_done: assert property (p_skip_done) else $error("skip not two cycles");
	a_excl: assert property (p_excl) else $error("flush with done");
	a_rd_wait: assert property (p_rd_wait) else $error("read wait too short");
	a_rd_bound: assert property (p_rd_bound) else $error("read never answered");
	a_hold: assert property (p_hold) else $error("read data moved");
endmodule : bacs_props_chk

bind bacs_alu_top bacs_props_chk #(.MEM_DEPTH(MEM_DEPTH)) u_chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.flush_pulse(flush_pulse), .done_pulse(done_pulse));

// ===== bacs_alu_top_tb.sv
/*
 * Self-checking bench for bacs_alu_top over AHB-Lite.
 * Assumes zero-wait writes and two-wait reads while the engine is idle.
 */
`timescale 1ns/10ps
module bacs_alu_top_tb;
	import bacs_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, flush_pulse, done_pulse;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int          n_errors, n_compared, n_flush, n_done;

	bacs_alu_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .flush_pulse(flush_pulse), .done_pulse(done_pulse));

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		if (flush_pulse === 1'b1) n_flush++;
		if (done_pulse === 1'b1) n_done++;
	end

	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		if (n >= 40) begin
			chk(32'h0, 32'h1);
			end_sim;
		end
	endtask : wait_rdy

	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy;
		rd = hrdata;
	endtask : xfer

	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, WORD_ZERO);
		chk(rd, exp);
	endtask : rdc

	// Nibble-wise reference: returns {carry out, adjusted byte}; digits corrected independently
	function logic [8:0] ref_adj(input logic [7:0] w, input logic c, input logic dig);
		logic [4:0] lo, hi;
		lo = {1'b0, w[3:0]} + ((w[3:0] > BCD_MAX || dig) ? 5'h06 : 5'h00);
		hi = {1'b0, w[7:4]} + ((w[7:4] > BCD_MAX || c) ? 5'h06 : 5'h00);
		return {hi[4], hi[3:0], lo[3:0]};
	endfunction : ref_adj

	////////////////////////////////////////////////////////////////////////
	task t_reset;
		for (int i = 0; i < 20; i += 4) rdc(8'(i), WORD_ZERO);
		wr(8'h18, 32'hFF);
		rdc(8'h18, WORD_ZERO);
	endtask : t_reset

	task automatic t_adj;
		logic [7:0] tw [0:5] = '{8'hA5, 8'hCE, 8'h12, 8'h12, 8'h99, 8'h9A};
		logic [1:0] tf [0:5] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h0, 2'h0};
		logic       ts [0:5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		logic [8:0] e;
		for (int i = 0; i < 6; i++) begin
			e = ref_adj(tw[i], tf[i][0], tf[i][1]);
			wr(OFS_FLAGS, {30'h0, tf[i]});
			wr(OFS_WORK, {24'h0, tw[i]});
			wr(OFS_CTRL, {16'h0, 8'h20 | 8'(i), 3'h0, ts[i], 2'h0, OP_ADJ});
			wr(OFS_MADDR, {24'h0, 8'h20 | 8'(i)});
			rdc(OFS_MDATA, {24'h0, e[7:0]});
			rdc(OFS_WORK, {24'h0, ts[i] ? tw[i] : e[7:0]});
			rdc(OFS_FLAGS, {30'h0, tf[i][1], e[8]});
			rdc(OFS_STATUS, 32'h10);
		end
	endtask : t_adj

	task automatic t_cmp;
		logic [7:0] tm [0:3] = '{8'h7F, 8'h80, 8'h81, 8'h00};
		logic [7:0] tw [0:3] = '{8'h80, 8'h80, 8'h80, 8'hFF};
		int         f0;
		for (int i = 0; i < 4; i++) begin
			f0 = n_flush;
			wr(OFS_FLAGS, 32'h3);
			wr(OFS_WORK, {24'h0, tw[i]});
			wr(OFS_MADDR, 32'h40);
			wr(OFS_MDATA, {24'h0, tm[i]});
			wr(OFS_CTRL, {16'h0, 8'h40, 6'h0, OP_CSLT});
			rdc(OFS_STATUS, (tm[i] < tw[i]) ? 32'h22 : 32'h10);
			chk(32'(n_flush - f0), {31'h0, tm[i] < tw[i]});
			rdc(OFS_FLAGS, 32'h3);
			rdc(OFS_WORK, {24'h0, tw[i]});
			rdc(OFS_MDATA, {24'h0, tm[i]});
		end
	endtask : t_cmp

	task automatic t_badop;
		logic [1:0] ops [0:1] = '{OP_NONE, 2'h3};
		for (int i = 0; i < 2; i++) begin
			wr(OFS_CTRL, {16'h0, 8'h55, 6'h0, ops[i]});
			rdc(OFS_STATUS, 32'h22);
			rdc(OFS_CTRL, 32'h0000_4002);
		end
	endtask : t_badop

	task end_sim;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5000) @(posedge hclk);
		n_errors++;
		end_sim;
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = WORD_ZERO;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = WORD_ZERO;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset;
		t_adj;
		t_cmp;
		t_badop;
		chk(32'(n_done), 32'h0A);
		chk(32'(n_flush), 32'h2);
		end_sim;
	end
endmodule : bacs_alu_top_tb

// ===== bacs_data_mem.sv
/*
 * Byte-wide data memory with one write port and one read port.
 * Read data come out of a register one clock after the address.
 * Assumes the owner never writes and reads conflicting words blindly.
 */
`timescale 1ns/10ps
module bacs_data_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 256,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data_q
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge hclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_data_q <= '0;
		end else begin
			rd_data_q <= mem[rd_addr];
		end
	end

endmodule : bacs_data_mem

// ===== bacs_nibble_adj.sv
/*
 * One packed-BCD digit corrector: adds six when the digit is above nine,
 * when its forcing flag is set, or when a carry would push nine past nine.
 * Purely combinational; instantiated once per nibble by the top.
 */
`timescale 1ns/10ps
module bacs_nibble_adj
	import bacs_pkg::*;
(
	input  wire logic [3:0] digit,
	input  wire logic       force_adj,
	input  wire logic       carry_in,
	output logic      [3:0] result,
	output logic            carry_out
);

	logic       adjust;
	logic [4:0] sum;

	// Digit above nine or flag set selects the correction
	assign adjust    = (digit > BCD_MAX) | force_adj | (carry_in & (digit == BCD_MAX));
	assign sum       = {1'b0, digit} + {1'b0, (adjust ? BCD_ADJ : 4'h0)} + {4'h0, carry_in};
	assign result    = sum[3:0];
	assign carry_out = sum[4];

endmodule : bacs_nibble_adj

// ===== bacs_pkg.sv
/*
 * Shared constants and carrier types for the decimal adjust and
 * compare-skip-less execution block: register map, field positions,
 * reset values, operation codes and sequencing counts.
 * Assumes a single 25 MHz clock and a 32-bit AHB-Lite register bus.
 */
package bacs_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets, low eight address bits
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_WORK   = 8'h04;
	localparam logic [7:0] OFS_FLAGS  = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_MADDR  = 8'h10;
	localparam logic [7:0] OFS_MDATA  = 8'h14;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CTRL_OP_LSB   = 0;
	localparam int CTRL_DEST_BIT = 4;
	localparam int CTRL_F_LSB    = 8;
	localparam int FLG_C_BIT     = 0;
	localparam int FLG_DIG_BIT   = 1;
	localparam int STS_BUSY_BIT  = 0;
	localparam int STS_SKIP_BIT  = 1;
	localparam int STS_CYC_LSB   = 4;

	////////////////////////////////////////////////////////////////////////
	// Operation codes
	localparam logic [1:0] OP_NONE = 2'h0;
	localparam logic [1:0] OP_ADJ  = 2'h1;
	localparam logic [1:0] OP_CSLT = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// Arithmetic and timing constants
	localparam logic [3:0] BCD_MAX     = 4'h9;
	localparam logic [3:0] BCD_ADJ     = 4'h6;
	localparam logic [1:0] RD_WAIT     = 2'h1;
	localparam logic [1:0] NOP_LAST_PH = 2'h3;
	localparam logic [1:0] CYC_SINGLE  = 2'h1;
	localparam logic [1:0] CYC_DOUBLE  = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0]  WORK_RST  = 8'h00;
	localparam logic [7:0]  MADDR_RST = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// Carrier types
	typedef struct packed {
		logic [7:0] f_addr;
		logic       dest_mem_only;
		logic [1:0] op;
	} bacs_ctrl_t;

	typedef struct packed {
		logic digit_carry_flag;
		logic carry;
	} bacs_flags_t;

	localparam bacs_ctrl_t  CTRL_RST  = '{f_addr: 8'h00, dest_mem_only: 1'b0, op: 2'h0};
	localparam bacs_flags_t FLAGS_RST = '{digit_carry_flag: 1'b0, carry: 1'b0};

endpackage : bacs_pkg
